/* i2c_ss_pkg.sv */
package i2c_ss_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the local register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_BUS_CONTROL = 2'h0;  // control, triggers read zero
  localparam logic [1:0] ADDR_BUS_STATUS  = 2'h1;  // bus status, read only
  localparam logic [1:0] ADDR_IRQ_STATUS  = 2'h2;  // sticky events, write one to clear
  localparam logic [1:0] ADDR_IRQ_MASK    = 2'h3;  // interrupt enables

  // ----------------------------------------------------------------
  // bus_control field positions
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE     = 7;  // serial_bus_enable
  localparam int CTL_WAIT_REL   = 5;  // wait_release, self clearing
  localparam int CTL_ACK_GEN    = 2;  // ack_generation_enable
  localparam int CTL_START_TRIG = 1;  // start_trigger
  localparam int CTL_STOP_TRIG  = 0;  // stop_trigger

  // ----------------------------------------------------------------
  // bus_status field positions
  // ----------------------------------------------------------------
  localparam int ST_MASTER    = 7;  // master_state
  localparam int ST_ARB_LOST  = 6;  // arbitration lost, cleared by status read
  localparam int ST_EXT_CODE  = 5;  // extended_code_received
  localparam int ST_ADDR_MAT  = 4;  // address_match
  localparam int ST_TX_STATE  = 3;  // transmit_state
  localparam int ST_ACK_DET   = 2;  // ack_detected
  localparam int ST_START_DET = 1;  // start_detected
  localparam int ST_STOP_DET  = 0;  // stop detected

  // ----------------------------------------------------------------
  // interrupt event bit positions
  // ----------------------------------------------------------------
  localparam int EV_START = 0;  // start condition seen
  localparam int EV_STOP  = 1;  // stop condition seen
  localparam int EV_ARB   = 2;  // arbitration lost
  localparam int EV_WAIT  = 3;  // wait period entered
  localparam int EV_W     = 4;  // number of events

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]      CTRL_RESET   = 8'h00;
  localparam logic [EV_W-1:0] IRQ_RESET    = 4'h0;
  localparam int              CLK_PERIOD_NS = 20;    // sys_clk_i, 50 MHz
  localparam int              HOLD_TIME_NS  = 4700;  // standard start/stop hold time
  localparam int              HOLD_CYCLES   =
    (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // least time, rounded up
  localparam int              CNT_W         = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;      // serial_bus_enable
    logic [1:0] rsv_hi;      // bit 6 unused, bit 5 wait_release strobe (never stored), read zero
    logic       wait_rel;    // unused (never stored)
    logic       rsv_lo;      // unused, read zero
    logic       ack_gen;     // ack_generation_enable
    logic       start_trig;  // start_trigger (reads zero)
    logic       stop_trig;   // stop_trigger (reads zero)
  } bus_ctrl_t;

  typedef struct packed {
    logic scl;  // serial_clock_line
    logic sda;  // serial_data_line
  } line_pair_t;

  typedef enum logic [2:0] {
    M_IDLE,
    M_START_HOLD,
    M_MASTER,
    M_STOP_SDA,
    M_STOP_SCL,
    M_STOP_HOLD,
    M_STOP_WAIT
  } mstate_t;

endpackage

/* i2c_line_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser for the bus lines, one per bit of the width
module i2c_line_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  // asynchronous and synchronised levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;       // first stage, read only by second stage
  logic [W-1:0] next_meta;  // next first stage
  logic [W-1:0] next_sync;  // next second stage

  // ----------------------------------------------------------------
  // next values; idle bus is high, so reset to ones
  // ----------------------------------------------------------------
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
    if (srst_i) begin
      next_meta = '1;
      next_sync = '1;
    end
  end

  // registers only
  always_ff @(posedge sys_clk_i) begin
    meta   <= next_meta;
    sync_o <= next_sync;
  end

endmodule
`default_nettype wire

/* i2c_start_stop_control.sv */
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module i2c_start_stop_control
  import i2c_ss_pkg::*;
#(
  parameter int HOLD_CNT = HOLD_CYCLES  // standard time in sys_clk_i cycles
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // bus lines, open drain
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // shift, ack and arbitration logic
  input  wire logic       arb_lost_i,
  input  wire logic       wait_req_i,
  input  wire logic       tx_set_i,
  input  wire logic       tx_data_low_i,
  input  wire logic       ack_detected_i,
  input  wire logic       address_match_i,
  input  wire logic       ext_code_i,
  output logic            ack_gen_enable_o,
  output logic            wait_release_o,
  // interrupt
  output logic            irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  line_pair_t            line_s;       // synchronised line levels
  line_pair_t            line_d;       // previous synchronised levels
  bus_ctrl_t             ctrl;         // stored control bits
  mstate_t               mst;          // master sequencer state
  logic [CNT_W-1:0]      hold_cnt;     // standard time counter
  logic                  bus_busy;     // between start and stop
  logic                  master;       // master_state
  logic                  tx_state;     // transmit_state
  logic                  wait_held;    // clock held low in wait
  logic                  arb_flag;     // arbitration lost flag
  logic                  start_flag;   // start_detected
  logic                  stop_flag;    // stop detected
  logic [EV_W-1:0]       irq_stat;     // sticky events
  logic [EV_W-1:0]       irq_mask;     // enables
  logic                  wrel_pulse;   // one-cycle wait release
  logic [7:0]            rdata;        // registered read data

  bus_ctrl_t             next_ctrl;
  mstate_t               next_mst;
  logic [CNT_W-1:0]      next_hold_cnt;
  logic                  next_bus_busy;
  logic                  next_master;
  logic                  next_tx_state;
  logic                  next_wait_held;
  logic                  next_arb_flag;
  logic                  next_start_flag;
  logic                  next_stop_flag;
  logic [EV_W-1:0]       next_irq_stat;
  logic [EV_W-1:0]       next_irq_mask;
  logic                  next_wrel_pulse;
  logic [7:0]            next_rdata;

  // decoded strobes and events
  logic                  wr_ctrl;      // write to bus_control
  logic                  start_det;    // data falls, clock high
  logic                  stop_det;     // data rises, clock high
  logic                  pull_scl;     // sequencer holds clock low
  logic                  pull_sda;     // sequencer holds data low
  logic [EV_W-1:0]       events;       // this cycle's events
  logic [CNT_W-1:0]      hold_last;    // final count value

  assign hold_last = CNT_W'(HOLD_CNT - 1);

  // ----------------------------------------------------------------
  // line sampling
  // ----------------------------------------------------------------
  i2c_line_sync #(
    .W (2)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    (line_s)
  );

  // conditions from read-back levels, second stage only
  always_comb begin
    start_det = line_d.sda & ~line_s.sda & line_s.scl & line_d.scl;
    stop_det  = ~line_d.sda & line_s.sda & line_s.scl & line_d.scl;
    wr_ctrl   = reg_wr_i & (reg_addr_i == ADDR_BUS_CONTROL);
  end

  // ----------------------------------------------------------------
  // control register and master sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl      = ctrl;
    next_mst       = mst;
    next_hold_cnt  = hold_cnt;
    next_master    = master;
    next_wrel_pulse = 1'b0;
    // software write; reserved bits never stored
    if (wr_ctrl) begin
      next_ctrl            = bus_ctrl_t'(reg_wdata_i);
      next_ctrl.rsv_hi     = 2'h0;
      next_ctrl.rsv_lo     = 1'b0;
      next_ctrl.wait_rel   = 1'b0;
      next_wrel_pulse      = reg_wdata_i[CTL_WAIT_REL] & reg_wdata_i[CTL_ENABLE];
      // triggers only set by a write; a zero write clears them
      next_ctrl.start_trig = reg_wdata_i[CTL_START_TRIG];
      next_ctrl.stop_trig  = reg_wdata_i[CTL_STOP_TRIG];
    end
    case (mst)
      M_IDLE: begin
        // a busy bus keeps the request pending until released
        if (ctrl.start_trig && !bus_busy && line_s.scl && line_s.sda) begin
          next_mst      = M_START_HOLD;
          next_hold_cnt = '0;
        end
      end
      M_START_HOLD: begin
        // data held low for the standard time, then clock low
        if (hold_cnt == hold_last) begin
          next_mst             = M_MASTER;
          next_master          = 1'b1;
          next_ctrl.start_trig = 1'b0;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      M_MASTER: begin
        // stop accepted only while master; the stop states time it
        if (ctrl.stop_trig) begin
          next_mst = M_STOP_SDA;
        end
      end
      M_STOP_SDA: begin
        next_mst = M_STOP_SCL;
      end
      M_STOP_SCL: begin
        // clock released; another master may stretch it
        if (line_s.scl) begin
          next_mst      = M_STOP_HOLD;
          next_hold_cnt = '0;
        end
      end
      M_STOP_HOLD: begin
        if (hold_cnt == hold_last) begin
          next_mst = M_STOP_WAIT;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      M_STOP_WAIT: begin
        // data released; idle once our own stop is seen
        if (stop_det) begin
          next_mst = M_IDLE;
        end
      end
      default: begin
        next_mst = M_IDLE;
      end
    endcase
    // stop detection ends mastership and the stop request
    if (stop_det) begin
      next_ctrl.stop_trig = 1'b0;
      next_master         = 1'b0;
      if (mst != M_STOP_WAIT && mst != M_IDLE) begin
        next_mst = M_IDLE;
      end
    end
    // lost arbitration drops both requests and mastership
    if (arb_lost_i) begin
      next_ctrl.start_trig = 1'b0;
      next_ctrl.stop_trig  = 1'b0;
      next_master          = 1'b0;
      next_mst             = M_IDLE;
    end
    // disabled interface: requests void, sequencer parked
    if (!next_ctrl.enable) begin
      next_ctrl.start_trig = 1'b0;
      next_ctrl.stop_trig  = 1'b0;
      next_master          = 1'b0;
      next_mst             = M_IDLE;
    end
    if (srst_i) begin
      next_ctrl       = bus_ctrl_t'(CTRL_RESET);
      next_mst        = M_IDLE;
      next_hold_cnt   = '0;
      next_master     = 1'b0;
      next_wrel_pulse = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge sys_clk_i) begin
    ctrl       <= next_ctrl;
    mst        <= next_mst;
    hold_cnt   <= next_hold_cnt;
    master     <= next_master;
    wrel_pulse <= next_wrel_pulse;
  end

  // ----------------------------------------------------------------
  // bus state, wait and status flags
  // ----------------------------------------------------------------
  always_comb begin
    next_bus_busy   = bus_busy;
    next_tx_state   = tx_state;
    next_wait_held  = wait_held;
    next_arb_flag   = arb_flag;
    next_start_flag = start_flag;
    next_stop_flag  = stop_flag;
    if (start_det) begin
      next_bus_busy   = 1'b1;
      next_start_flag = 1'b1;
      next_stop_flag  = 1'b0;
    end
    if (stop_det) begin
      next_bus_busy   = 1'b0;
      next_start_flag = 1'b0;
      next_stop_flag  = 1'b1;
      next_wait_held  = 1'b0;
    end
    // release first, so a new wait in the same cycle still holds
    if (wrel_pulse) begin
      next_wait_held = 1'b0;
      next_tx_state  = 1'b0;
    end
    // a stop request hands the clock to the stop sequencer
    if (mst == M_MASTER && ctrl.stop_trig) begin
      next_wait_held = 1'b0;
    end
    if (wait_req_i && ctrl.enable) begin
      next_wait_held = 1'b1;
    end
    // new master pulls the clock low; releasing both lines would form a stop
    if (mst == M_START_HOLD && next_mst == M_MASTER) begin
      next_wait_held = 1'b1;
    end
    if (tx_set_i && ctrl.enable) begin
      next_tx_state = 1'b1;
    end
    // read clears arbitration flag, a new loss wins
    if (reg_rd_i && reg_addr_i == ADDR_BUS_STATUS) begin
      next_arb_flag = 1'b0;
    end
    if (arb_lost_i) begin
      next_arb_flag = 1'b1;
    end
    if (!ctrl.enable) begin
      next_bus_busy   = 1'b0;
      next_tx_state   = 1'b0;
      next_wait_held  = 1'b0;
      next_arb_flag   = 1'b0;
      next_start_flag = 1'b0;
      next_stop_flag  = 1'b0;
    end
    if (srst_i) begin
      next_bus_busy   = 1'b0;
      next_tx_state   = 1'b0;
      next_wait_held  = 1'b0;
      next_arb_flag   = 1'b0;
      next_start_flag = 1'b0;
      next_stop_flag  = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge sys_clk_i) begin
    line_d     <= srst_i ? line_pair_t'(2'h3) : line_s;
    bus_busy   <= next_bus_busy;
    tx_state   <= next_tx_state;
    wait_held  <= next_wait_held;
    arb_flag   <= next_arb_flag;
    start_flag <= next_start_flag;
    stop_flag  <= next_stop_flag;
  end

  // ----------------------------------------------------------------
  // interrupts and read data
  // ----------------------------------------------------------------
  always_comb begin
    events              = '0;
    events[EV_START]    = start_det;
    events[EV_STOP]     = stop_det;
    events[EV_ARB]      = arb_lost_i;
    events[EV_WAIT]     = wait_req_i & ctrl.enable;
    next_irq_stat       = irq_stat;
    next_irq_mask       = irq_mask;
    next_rdata          = 8'h00;
    if (reg_wr_i && reg_addr_i == ADDR_IRQ_STATUS) begin
      next_irq_stat = irq_stat & ~reg_wdata_i[EV_W-1:0];
    end else if (reg_wr_i && reg_addr_i == ADDR_IRQ_MASK) begin
      next_irq_mask = reg_wdata_i[EV_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_BUS_CONTROL) begin
        next_rdata                 = ctrl;
        next_rdata[CTL_START_TRIG] = 1'b0;
        next_rdata[CTL_STOP_TRIG]  = 1'b0;
        next_rdata[CTL_WAIT_REL]   = 1'b0;
      end else if (reg_addr_i == ADDR_BUS_STATUS) begin
        next_rdata[ST_MASTER]    = master;
        next_rdata[ST_ARB_LOST]  = arb_flag;
        next_rdata[ST_EXT_CODE]  = ext_code_i;
        next_rdata[ST_ADDR_MAT]  = address_match_i;
        next_rdata[ST_TX_STATE]  = tx_state;
        next_rdata[ST_ACK_DET]   = ack_detected_i;
        next_rdata[ST_START_DET] = start_flag;
        next_rdata[ST_STOP_DET]  = stop_flag;
      end else if (reg_addr_i == ADDR_IRQ_STATUS) begin
        next_rdata[EV_W-1:0] = irq_stat;
      end else begin
        next_rdata[EV_W-1:0] = irq_mask;
      end
    end
    if (srst_i) begin
      next_irq_stat = IRQ_RESET;
      next_irq_mask = IRQ_RESET;
      next_rdata    = 8'h00;
    end
  end

  // registers only
  always_ff @(posedge sys_clk_i) begin
    irq_stat <= next_irq_stat;
    irq_mask <= next_irq_mask;
    rdata    <= next_rdata;
  end

  // ----------------------------------------------------------------
  // pin drive: pull low or release, never drive high
  // ----------------------------------------------------------------
  always_comb begin
    pull_sda = (mst == M_START_HOLD) | (mst == M_MASTER && ctrl.stop_trig)
             | (mst == M_STOP_SDA) | (mst == M_STOP_SCL) | (mst == M_STOP_HOLD);
    pull_scl = (mst == M_STOP_SDA) | (mst == M_MASTER && (wait_held || ctrl.stop_trig));
    // transmitted zeros only while transmit_state holds; release frees data
    sda_oe_o = pull_sda | (tx_state & tx_data_low_i & ctrl.enable);
    scl_oe_o = pull_scl | wait_held;
    sda_o    = 1'b0;
    scl_o    = 1'b0;
  end

  assign reg_rdata_o      = rdata;
  assign ack_gen_enable_o = ctrl.ack_gen;
  assign wait_release_o   = wrel_pulse;
  assign irq_o            = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

/* i2c_ss_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

module i2c_ss_assertions
  import i2c_ss_pkg::*;
#(
  parameter int HOLD_CNT = 4  // standard time in cycles
) (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  // register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // bus lines
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       scl_o,
  input wire logic       sda_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_oe_o,
  // side signals
  input wire logic       ack_detected_i,
  input wire logic       address_match_i,
  input wire logic       ext_code_i,
  input wire logic       wait_release_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // ----------
  // helper
  // ----------
  logic [15:0] low_run;       // cycles data low with clock free
  logic [15:0] next_low_run;  // next count

  // run length from the pin drive enables, not the sequencer's own count
  always_comb begin
    next_low_run = (sda_oe_o && !scl_oe_o) ? low_run + 16'h1 : 16'h0;
  end

  // register the count
  always_ff @(posedge sys_clk_i) begin
    low_run <= srst_i ? 16'h0 : next_low_run;
  end

  // ----------
  // assertions
  // ----------
  chk_trig_reads_zero: assert property (
    reg_rd_i && reg_addr_i == ADDR_BUS_CONTROL
    |=> !reg_rdata_o[CTL_START_TRIG] && !reg_rdata_o[CTL_STOP_TRIG])
    else $error("trigger bit read back as one");
  chk_hold_time: assert property (
    $fell(sda_oe_o) && !$past(scl_oe_o) |-> low_run >= HOLD_CNT)
    else $error("data released before the standard time");
  chk_start_free_bus: assert property (
    // data already falls in this cycle, so judge the levels before it
    $rose(sda_oe_o) && !scl_oe_o |-> $past(scl_i) && $past(sda_i))
    else $error("start driven on a busy bus");
  chk_wrel_pulse: assert property (
    reg_wr_i && reg_addr_i == ADDR_BUS_CONTROL
    && reg_wdata_i[CTL_WAIT_REL] && reg_wdata_i[CTL_ENABLE]
    |=> wait_release_o ##1 !wait_release_o)
    else $error("wait release pulse wrong");
  chk_wrel_frees: assert property (
    wait_release_o |=> !scl_oe_o && !sda_oe_o)
    else $error("lines still driven after wait release");
  chk_disable_parks: assert property (
    reg_wr_i && reg_addr_i == ADDR_BUS_CONTROL && !reg_wdata_i[CTL_ENABLE]
    |-> ##2 (!sda_oe_o && !scl_oe_o) [*4])
    else $error("lines driven while disabled");
  chk_open_drain: assert property (
    !sda_o && !scl_o)
    else $error("bus line driven high");
  chk_status_bits: assert property (
    reg_rd_i && reg_addr_i == ADDR_BUS_STATUS
    && $stable({ack_detected_i, address_match_i, ext_code_i})
    |=> reg_rdata_o[ST_ACK_DET] == $past(ack_detected_i)
    && reg_rdata_o[ST_ADDR_MAT] == $past(address_match_i)
    && reg_rdata_o[ST_EXT_CODE] == $past(ext_code_i))
    else $error("status field in wrong place");

  // main scenarios
  cov_start: cover property ($rose(sda_oe_o) && !scl_oe_o);
  cov_release: cover property (wait_release_o);
  cov_stop: cover property ($fell(sda_oe_o) && !$past(scl_oe_o));
endmodule

`default_nettype wire

/* i2c_bus_partner.sv */
`timescale 1ns/10ps
`default_nettype none

// other masters on the bus; lines have pull-ups, so idle is high
module i2c_bus_partner (
  // pulls, high = line pulled low
  output logic scl_pull_o,
  output logic sda_pull_o
);
  // ----------
  // traffic
  // ----------
  // clock stands still between frames
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end

  // one foreign frame: start, some clocks, stop
  task automatic frame(input int bits);
    sda_pull_o = 1'b1;
    #80;
    repeat (bits) begin
      scl_pull_o = 1'b1;
      #80;
      scl_pull_o = 1'b0;
      #80;
    end
    scl_pull_o = 1'b1;
    #80;
    scl_pull_o = 1'b0;
    #80;
    sda_pull_o = 1'b0;  // data rises with clock high
  endtask
endmodule

`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
  import i2c_ss_pkg::*;
  localparam int HOLD = 4;  // short standard time keeps runs brief
  // ----------
  // signals
  // ----------
  logic       sys_clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o, irq_o;
  logic       arb_lost_i = 1'b0, wait_req_i = 1'b0, tx_set_i = 1'b0;
  logic       tx_data_low_i = 1'b0, ack_detected_i = 1'b0;
  logic       address_match_i = 1'b0, ext_code_i = 1'b0;
  logic       scl_pull, sda_pull, ack_gen;
  logic [7:0] rdata_q;
  int         errors = 0, compares = 0;

  always #10 sys_clk_i = ~sys_clk_i;
  // wired-and with pull-ups
  assign scl_i = !(scl_oe_o || scl_pull);
  assign sda_i = !(sda_oe_o || sda_pull);

  i2c_start_stop_control #(.HOLD_CNT(HOLD)) u_dut (
    .*, .ack_gen_enable_o(ack_gen), .wait_release_o());
  i2c_bus_partner u_partner (.scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

  // ----------
  // helpers
  // ----------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // data stand one cycle only, so sample just after the taking edge
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rdata_q = reg_rdata_o;
  endtask
  task automatic poll(input int idx, input logic val, input string what);
    int n;
    n = 0;
    rd(ADDR_BUS_STATUS);
    while (rdata_q[idx] !== val && n < 80) begin
      rd(ADDR_BUS_STATUS);
      n++;
    end
    chk(what, {7'h0, rdata_q[idx]}, {7'h0, val});
  endtask
  // data line must stay undriven for a while
  task automatic quiet(input int cyc, input string what);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(negedge sys_clk_i);
      hits += int'(sda_oe_o !== 1'b0);
    end
    chk(what, hits[7:0], 8'h00);
  endtask
  task automatic do_stop;
    wr(ADDR_BUS_CONTROL, 8'h81);
    poll(ST_STOP_DET, 1'b1, "stop_det");
    chk("master_off", rdata_q & 8'h80, 8'h00);
    quiet(30, "no_repeat");
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0]);
      chk("reset_value", rdata_q, 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic t_master;
    @(posedge sys_clk_i);
    ack_detected_i <= 1'b1;
    address_match_i <= 1'b1;
    wr(ADDR_BUS_CONTROL, 8'h82);
    rd(ADDR_BUS_CONTROL);
    chk("ctrl_readback", rdata_q, 8'h80);
    chk("ack_gen_off", {7'h0, ack_gen}, 8'h00);
    poll(ST_MASTER, 1'b1, "master_on");
    chk("status_bits", rdata_q & 8'hb6, 8'h96);
    @(posedge sys_clk_i);
    wait_req_i <= 1'b1;
    tx_set_i <= 1'b1;
    tx_data_low_i <= 1'b1;
    @(posedge sys_clk_i);
    wait_req_i <= 1'b0;
    tx_set_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("wait_lines", {6'h0, scl_oe_o, sda_oe_o}, 8'h03);
    rd(ADDR_BUS_STATUS);
    chk("tx_on", rdata_q & 8'h08, 8'h08);
    wr(ADDR_BUS_CONTROL, 8'ha0);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("wait_freed", {6'h0, scl_oe_o, sda_oe_o}, 8'h00);
    rd(ADDR_BUS_STATUS);
    chk("tx_off", rdata_q & 8'h08, 8'h00);
    @(posedge sys_clk_i);
    tx_data_low_i <= 1'b0;
    do_stop;
    $display("test master done");
  endtask
  task automatic t_irq;
    rd(ADDR_IRQ_STATUS);
    chk("irq_events", rdata_q, 8'h0b);
    chk("irq_masked", {7'h0, irq_o}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(negedge sys_clk_i);
    chk("irq_on", {7'h0, irq_o}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h02);
    repeat (2) @(negedge sys_clk_i);
    chk("irq_cleared", {7'h0, irq_o}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h04);
    @(posedge sys_clk_i);
    arb_lost_i <= 1'b1;
    @(posedge sys_clk_i);
    arb_lost_i <= 1'b0;
    rd(ADDR_BUS_STATUS);
    chk("arb_flag", rdata_q & 8'h40, 8'h40);
    chk("irq_arb", {7'h0, irq_o}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h0f);
    wr(ADDR_IRQ_MASK, 8'h00);
    $display("test irq done");
  endtask
  // start asked while another master owns the bus
  task automatic t_busy(input logic dis);
    fork
      u_partner.frame(6);
      begin
        repeat (10) @(posedge sys_clk_i);
        wr(ADDR_BUS_CONTROL, 8'h82);
        if (dis) begin
          wr(ADDR_BUS_CONTROL, 8'h00);
          wr(ADDR_BUS_CONTROL, 8'h84);
        end
        quiet(30, "busy_wait");
      end
    join
    if (dis) begin
      quiet(40, "disabled_req");
      chk("ack_gen_on", {7'h0, ack_gen}, 8'h01);
    end else begin
      poll(ST_MASTER, 1'b1, "late_start");
      do_stop;
    end
    $display("test busy done");
  endtask

  // ----------
  // run
  // ----------
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset;
    t_master;
    t_irq;
    t_busy(1'b0);
    t_busy(1'b1);
    give_verdict;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #1000000;
    errors++;
    give_verdict;
  end
endmodule

bind i2c_start_stop_control i2c_ss_assertions #(.HOLD_CNT(HOLD_CNT)) u_chk (.*);

`default_nettype wire
